// *** irq_pkg.sv ***
// Constants shared by the interrupt controller files
package irq_pkg;
   localparam int          NUM_SRC       = 7;
   localparam int          LVL_W         = 2;
   localparam int          SRC_W         = 3;
   localparam int          ADDR_W        = 24;
   localparam int          DATA_W        = 32;
   localparam int          CYCLE_STATES  = 4;
   localparam int          LAT_MIN       = 17;
   localparam int          LAT_MAX       = 72;
   // Source order is also the fixed order within a level, index 0 wins
   localparam logic [2:0]  SRC_EXT_A     = 3'h0;
   localparam logic [2:0]  SRC_TMR_A     = 3'h1;
   localparam logic [2:0]  SRC_EXT_B     = 3'h2;
   localparam logic [2:0]  SRC_TMR_B     = 3'h3;
   localparam logic [2:0]  SRC_SERIAL    = 3'h4;
   localparam logic [2:0]  SRC_TMR_C     = 3'h5;
   localparam logic [2:0]  SRC_CNT_ARR   = 3'h6;
   localparam logic [23:0] VEC_BASE      = 24'hFF0003;
   localparam logic [23:0] VEC_STEP      = 24'h000008;
   localparam logic [23:0] VEC_TRAP      = 24'hFF007B;
   localparam logic [2:0]  STACK_LEGACY  = 3'h2;
   localparam logic [2:0]  STACK_FULL    = 3'h4;
   // Register byte addresses
   localparam logic [7:0]  ADDR_ENABLE   = 8'h00;
   localparam logic [7:0]  ADDR_PRIO     = 8'h04;
   localparam logic [7:0]  ADDR_MODE     = 8'h08;
   localparam logic [7:0]  ADDR_STATUS   = 8'h0C;
   localparam logic [7:0]  ADDR_MASK     = 8'h10;
   localparam logic [7:0]  ADDR_PEND     = 8'h14;
   localparam logic [7:0]  ADDR_VECTOR   = 8'h18;
   // Enable register fields
   localparam int          EN_GLOBAL_BIT = 7;
   // Mode register fields
   localparam int          MODE_LEGACY   = 0;
   localparam int          MODE_EDGE_A   = 1;
   localparam int          MODE_EDGE_B   = 2;
   // Event status bits
   localparam int          EV_TAKEN      = 0;
   localparam int          EV_TRAP       = 1;
   localparam int          EV_W          = 2;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : irq_pkg

// *** irq_prio_resolve.sv ***
// Combinational priority resolver over levels and fixed order
`timescale 1ns/1ps
`default_nettype none
module irq_prio_resolve #(
   parameter int N = irq_pkg::NUM_SRC
) (
   input  wire logic [N-1:0]                 req,
   input  wire logic [2*N-1:0]               prio,
   output logic                              found,
   output logic [irq_pkg::SRC_W-1:0]         src,
   output logic [irq_pkg::LVL_W-1:0]         lvl
);
   always_comb begin
      found = 1'b0;
      src   = '0;
      lvl   = '0;
      // Strict greater keeps the lower index within a level
      for (int i = 0; i < N; i++) begin
         if (req[i] && (!found || prio[2*i +: 2] > lvl)) begin
            found = 1'b1;
            src   = irq_pkg::SRC_W'(i);
            lvl   = prio[2*i +: 2];
         end
      end
   end
endmodule : irq_prio_resolve
`default_nettype wire

// *** irq_state_div.sv ***
// Divider giving one pulse per interrupt cycle of four states
`timescale 1ns/1ps
`default_nettype none
module irq_state_div #(
   parameter int STATES = irq_pkg::CYCLE_STATES
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   output logic      tick
);
   logic [3:0] cnt_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
         tick    <= 1'b0;
      end else begin
         tick <= (cnt_reg == 4'(STATES - 1));
         if (cnt_reg == 4'(STATES - 1)) begin
            cnt_reg <= '0;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
         end
      end
   end
endmodule : irq_state_div
`default_nettype wire

// *** interrupt_priority_vectoring.sv ***
// Interrupt priority and vectoring controller with AXI4-Lite registers
// Behaviour
// - Seven maskable sources plus one software trap
// - Two pins, three timers, serial, counter array
// - Four programmable levels, higher level served first
// - Fixed order breaks ties within one level
// - Fixed vector address for each source
// - Vectoring clears timer A and B and edge pin flags
// - Sampling and resolution every four-state cycle
// - Response latency seventeen to seventy-two states; here irq_call rises at the tick after the request is sampled
// - Trap instruction vectors to its own address
// - Trap beats every maskable request
// - Legacy mode stacks two bytes, else four
`timescale 1ns/1ps
`default_nettype none
module interrupt_priority_vectoring #(
   parameter int N = irq_pkg::NUM_SRC
) (
   input  wire logic                         aclk,
   input  wire logic                         aresetn,
   input  wire logic                         ext_irq_a_n,
   input  wire logic                         ext_irq_b_n,
   input  wire logic                         tmr_a_overflow,
   input  wire logic                         tmr_b_overflow,
   input  wire logic                         tmr_c_overflow,
   input  wire logic                         tmr_c_external_flag,
   input  wire logic                         serial_rx_done,
   input  wire logic                         serial_tx_done,
   input  wire logic                         counter_array_overflow,
   input  wire logic [4:0]                   counter_module_match,
   input  wire logic                         trap_exec,
   input  wire logic                         core_ack,
   input  wire logic                         core_reti,
   output logic                              irq_call,
   output logic [irq_pkg::ADDR_W-1:0]        irq_vector,
   output logic [2:0]                        irq_stack_bytes,
   output logic                              tmr_a_clear,
   output logic                              tmr_b_clear,
   output logic                              irq,
   input  wire logic [7:0]                   s_axi_awaddr,
   input  wire logic                         s_axi_awvalid,
   output logic                              s_axi_awready,
   input  wire logic [irq_pkg::DATA_W-1:0]   s_axi_wdata,
   input  wire logic [3:0]                   s_axi_wstrb,
   input  wire logic                         s_axi_wvalid,
   output logic                              s_axi_wready,
   output logic [1:0]                        s_axi_bresp,
   output logic                              s_axi_bvalid,
   input  wire logic                         s_axi_bready,
   input  wire logic [7:0]                   s_axi_araddr,
   input  wire logic                         s_axi_arvalid,
   output logic                              s_axi_arready,
   output logic [irq_pkg::DATA_W-1:0]        s_axi_rdata,
   output logic [1:0]                        s_axi_rresp,
   output logic                              s_axi_rvalid,
   input  wire logic                         s_axi_rready
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CALL = 3'b010,
      ST_WAIT = 3'b100
   } vec_state_e;

   vec_state_e                       state_reg;
   logic [7:0]                       enable_reg;
   logic [2*N-1:0]                   prio_reg;
   logic [2:0]                       mode_reg;
   logic [irq_pkg::EV_W-1:0]         status_reg;
   logic [irq_pkg::EV_W-1:0]         mask_reg;
   logic                             ext_a_pending;
   logic                             ext_b_pending;
   logic [1:0]                       ext_a_sync;
   logic [1:0]                       ext_b_sync;
   logic                             ext_a_prev;
   logic                             ext_b_prev;
   logic [N-1:0]                     flag;
   logic [N-1:0]                     gated;
   logic [N-1:0]                     sample_reg;
   logic                             trap_reg;
   logic [3:0]                       active_reg;
   logic                             tick;
   logic                             found;
   logic [irq_pkg::SRC_W-1:0]        win_src;
   logic [irq_pkg::LVL_W-1:0]        win_lvl;
   logic [irq_pkg::SRC_W-1:0]        cur_src_reg;
   logic                             cur_trap_reg;
   logic                             preempt_ok;
   logic [irq_pkg::EV_W-1:0]         ev;
   logic [7:0]                       aw_reg;
   logic                             aw_have;
   logic [irq_pkg::DATA_W-1:0]       w_reg;
   logic [3:0]                       ws_reg;
   logic                             w_have;
   logic                             wr_go;
   logic                             wr_ok;

   function automatic logic [23:0] vec_of(input logic [2:0] s);
      vec_of = irq_pkg::VEC_BASE + 24'(s) * irq_pkg::VEC_STEP;
   endfunction : vec_of

   function automatic logic [1:0] top_lvl(input logic [3:0] act);
      top_lvl = 2'h0;
      for (int i = 0; i < 4; i++) begin
         if (act[i]) begin
            top_lvl = 2'(i);
         end
      end
   endfunction : top_lvl

   irq_state_div u_div (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   // Pins cross two flops; only the second stage is read
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_a_sync <= 2'h3;
         ext_b_sync <= 2'h3;
         ext_a_prev <= 1'b1;
         ext_b_prev <= 1'b1;
      end else begin
         ext_a_sync <= {ext_a_sync[0], ext_irq_a_n};
         ext_b_sync <= {ext_b_sync[0], ext_irq_b_n};
         ext_a_prev <= ext_a_sync[1];
         ext_b_prev <= ext_b_sync[1];
      end
   end

   // Edge flags latch a falling edge; vectoring clears, a new edge wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_a_pending <= 1'b0;
         ext_b_pending <= 1'b0;
      end else begin
         if (ext_a_prev && !ext_a_sync[1]) begin
            ext_a_pending <= 1'b1;
         end else if (state_reg == ST_CALL && !cur_trap_reg && cur_src_reg == irq_pkg::SRC_EXT_A) begin
            ext_a_pending <= 1'b0;
         end
         if (ext_b_prev && !ext_b_sync[1]) begin
            ext_b_pending <= 1'b1;
         end else if (state_reg == ST_CALL && !cur_trap_reg && cur_src_reg == irq_pkg::SRC_EXT_B) begin
            ext_b_pending <= 1'b0;
         end
      end
   end

   always_comb begin
      flag = '0;
      flag[irq_pkg::SRC_EXT_A]   = mode_reg[irq_pkg::MODE_EDGE_A] ? ext_a_pending : !ext_a_sync[1];
      flag[irq_pkg::SRC_TMR_A]   = tmr_a_overflow;
      flag[irq_pkg::SRC_EXT_B]   = mode_reg[irq_pkg::MODE_EDGE_B] ? ext_b_pending : !ext_b_sync[1];
      flag[irq_pkg::SRC_TMR_B]   = tmr_b_overflow;
      flag[irq_pkg::SRC_SERIAL]  = serial_rx_done | serial_tx_done;
      flag[irq_pkg::SRC_TMR_C]   = tmr_c_overflow | tmr_c_external_flag;
      flag[irq_pkg::SRC_CNT_ARR] = counter_array_overflow | (|counter_module_match);
   end

   assign gated = flag & enable_reg[N-1:0] & {N{enable_reg[irq_pkg::EN_GLOBAL_BIT]}};

   // Maskable requests are sampled once per interrupt cycle; the trap latches in any cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sample_reg <= '0;
         trap_reg   <= 1'b0;
      end else begin
         if (tick) begin
            sample_reg <= gated;
         end
         if (trap_exec) begin
            trap_reg <= 1'b1;
         end else if (state_reg == ST_CALL && cur_trap_reg) begin
            trap_reg <= 1'b0;
         end
      end
   end

   irq_prio_resolve #(.N(N)) u_res (
      .req   (sample_reg),
      .prio  (prio_reg),
      .found (found),
      .src   (win_src),
      .lvl   (win_lvl)
   );

   assign preempt_ok = (active_reg == 4'h0) || (win_lvl > top_lvl(active_reg));

   // Vectoring sequence; irq_call holds until the core takes it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg    <= ST_IDLE;
         cur_src_reg  <= '0;
         cur_trap_reg <= 1'b0;
         irq_call     <= 1'b0;
         irq_vector   <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (trap_reg) begin
                  cur_trap_reg <= 1'b1;
                  irq_vector   <= irq_pkg::VEC_TRAP;
                  irq_call     <= 1'b1;
                  state_reg    <= ST_WAIT;
               end else if (tick && found && preempt_ok) begin
                  cur_trap_reg <= 1'b0;
                  cur_src_reg  <= win_src;
                  irq_vector   <= vec_of(win_src);
                  irq_call     <= 1'b1;
                  state_reg    <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (core_ack) begin
                  irq_call  <= 1'b0;
                  state_reg <= ST_CALL;
               end
            end
            ST_CALL: begin
               state_reg <= ST_IDLE;
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Timer clear pulses and nesting record at the call
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tmr_a_clear     <= 1'b0;
         tmr_b_clear     <= 1'b0;
         active_reg      <= '0;
         irq_stack_bytes <= irq_pkg::STACK_FULL;
      end else begin
         tmr_a_clear     <= state_reg == ST_CALL && !cur_trap_reg && cur_src_reg == irq_pkg::SRC_TMR_A;
         tmr_b_clear     <= state_reg == ST_CALL && !cur_trap_reg && cur_src_reg == irq_pkg::SRC_TMR_B;
         irq_stack_bytes <= mode_reg[irq_pkg::MODE_LEGACY] ? irq_pkg::STACK_LEGACY : irq_pkg::STACK_FULL;
         // A return and a new call in one cycle both take effect
         if (core_reti) begin
            active_reg[top_lvl(active_reg)] <= 1'b0;
         end
         if (state_reg == ST_CALL && !cur_trap_reg) begin
            active_reg[prio_reg[2*cur_src_reg +: 2]] <= 1'b1;
         end
      end
   end

   // Write channel: address and data taken in either order
   assign wr_go = aw_have && w_have && !s_axi_bvalid;
   assign wr_ok = aw_reg == irq_pkg::ADDR_ENABLE || aw_reg == irq_pkg::ADDR_PRIO || aw_reg == irq_pkg::ADDR_MODE
                  || aw_reg == irq_pkg::ADDR_STATUS || aw_reg == irq_pkg::ADDR_MASK;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have       <= 1'b0;
         w_have        <= 1'b0;
         aw_reg        <= '0;
         w_reg         <= '0;
         ws_reg        <= '0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= irq_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have <= 1'b1;
            aw_reg  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have <= 1'b1;
            w_reg  <= s_axi_wdata;
            ws_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have      <= 1'b0;
            w_have       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Software registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_reg <= '0;
         prio_reg   <= '0;
         mode_reg   <= '0;
         mask_reg   <= '0;
      end else if (wr_go && ws_reg[0]) begin
         if (aw_reg == irq_pkg::ADDR_ENABLE) begin
            enable_reg <= w_reg[7:0];
         end else if (aw_reg == irq_pkg::ADDR_MODE) begin
            mode_reg <= w_reg[2:0];
         end else if (aw_reg == irq_pkg::ADDR_MASK) begin
            mask_reg <= w_reg[irq_pkg::EV_W-1:0];
         end else if (aw_reg == irq_pkg::ADDR_PRIO) begin
            prio_reg[7:0] <= w_reg[7:0];
         end
      end
      if (aresetn && wr_go && aw_reg == irq_pkg::ADDR_PRIO && ws_reg[1]) begin
         prio_reg[2*N-1:8] <= w_reg[2*N-1:8];
      end
   end

   // Sticky events; a new event wins over a write-one clear
   always_comb begin
      ev = '0;
      ev[irq_pkg::EV_TAKEN] = state_reg == ST_CALL && !cur_trap_reg;
      ev[irq_pkg::EV_TRAP]  = state_reg == ST_CALL && cur_trap_reg;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_reg <= '0;
         irq        <= 1'b0;
      end else begin
         if (wr_go && ws_reg[0] && aw_reg == irq_pkg::ADDR_STATUS) begin
            status_reg <= (status_reg & ~w_reg[irq_pkg::EV_W-1:0]) | ev;
         end else begin
            status_reg <= status_reg | ev;
         end
         irq <= |(status_reg & mask_reg);
      end
   end

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= irq_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= irq_pkg::RESP_OKAY;
            s_axi_rdata  <= '0;
            if (s_axi_araddr == irq_pkg::ADDR_ENABLE) begin
               s_axi_rdata[7:0] <= enable_reg;
            end else if (s_axi_araddr == irq_pkg::ADDR_PRIO) begin
               s_axi_rdata[2*N-1:0] <= prio_reg;
            end else if (s_axi_araddr == irq_pkg::ADDR_MODE) begin
               s_axi_rdata[2:0] <= mode_reg;
            end else if (s_axi_araddr == irq_pkg::ADDR_STATUS) begin
               s_axi_rdata[irq_pkg::EV_W-1:0] <= status_reg;
            end else if (s_axi_araddr == irq_pkg::ADDR_MASK) begin
               s_axi_rdata[irq_pkg::EV_W-1:0] <= mask_reg;
            end else if (s_axi_araddr == irq_pkg::ADDR_PEND) begin
               s_axi_rdata[N-1:0]   <= flag;
               s_axi_rdata[N+3:N]   <= active_reg;
            end else if (s_axi_araddr == irq_pkg::ADDR_VECTOR) begin
               s_axi_rdata[23:0] <= irq_vector;
            end else begin
               s_axi_rresp <= irq_pkg::RESP_SLVERR;
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   trap_first_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_IDLE && trap_reg) |=> (irq_call && irq_vector == irq_pkg::VEC_TRAP))
      else $error("trap not served first");

   vector_fixed_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_IDLE && !trap_reg && tick && found && preempt_ok)
      |=> irq_vector == irq_pkg::VEC_BASE + 24'($past(win_src)) * irq_pkg::VEC_STEP)
      else $error("wrong vector");

   cycle_four_a: assert property (@(posedge aclk) disable iff (!aresetn)
      tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
      else $error("interrupt cycle not four states");

   gate_enable_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !enable_reg[irq_pkg::EN_GLOBAL_BIT] |-> gated == '0)
      else $error("global enable not gating");

   no_preempt_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_WAIT && $rose(irq_call) && !cur_trap_reg && $past(active_reg) != 4'h0)
      |-> $past(win_lvl) > top_lvl($past(active_reg)))
      else $error("preempted at equal or lower level");

   timer_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_CALL && !cur_trap_reg && cur_src_reg == irq_pkg::SRC_TMR_A) |=> tmr_a_clear)
      else $error("timer flag not cleared");

   stack_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
      mode_reg[irq_pkg::MODE_LEGACY] [*2] |-> irq_stack_bytes == irq_pkg::STACK_LEGACY)
      else $error("stack byte count wrong");

   level_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (found && sample_reg[irq_pkg::SRC_EXT_A]
       && prio_reg[1:0] == 2'h3) |-> win_src == irq_pkg::SRC_EXT_A)
      else $error("fixed order broken");

   latency_a: assert property (@(posedge aclk) disable iff (!aresetn)
      (state_reg == ST_IDLE && trap_reg) |-> ##[1:8] irq_call)
      else $error("call too late");
endmodule : interrupt_priority_vectoring
`default_nettype wire

// *** core_model.sv ***
// Behavioural processor core answering interrupt calls
`timescale 1ns/1ps
`default_nettype none
module core_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        irq_call,
   input  wire logic [23:0] irq_vector,
   input  wire logic [2:0]  irq_stack_bytes,
   output logic             core_ack,
   output logic             core_reti,
   output logic [23:0]      last_vec,
   output logic [2:0]       last_stack,
   output logic [7:0]       ncalls
);
   logic [3:0] hcnt;
   // Handler runs fourteen cycles, long enough to be preempted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {core_ack, core_reti, last_vec, last_stack, ncalls, hcnt} <= '0;
      end else begin
         core_reti <= (hcnt == 4'hE);
         hcnt <= (hcnt != 4'h0 && hcnt != 4'hF) ? hcnt + 4'h1 : 4'h0;
         if (irq_call && !core_ack) begin
            core_ack <= 1'b1;
            last_vec <= irq_vector;
            last_stack <= irq_stack_bytes;
            ncalls <= ncalls + 8'h01;
            hcnt <= 4'h1;
         end else if (!irq_call) begin
            core_ack <= 1'b0;
         end
      end
   end
endmodule : core_model
`default_nettype wire

// *** tb.sv ***
// Testbench for the interrupt priority controller
`timescale 1ns/1ps
`default_nettype none
module tb;
   localparam logic [23:0] VB = irq_pkg::VEC_BASE;
   localparam logic [23:0] VS = irq_pkg::VEC_STEP;
   logic        aclk, aresetn, ext_irq_a_n, ext_irq_b_n, tmr_a_overflow, tmr_b_overflow, tmr_c_overflow;
   logic        tmr_c_external_flag, serial_rx_done, serial_tx_done, counter_array_overflow, trap_exec;
   logic        core_ack, core_reti, irq_call, tmr_a_clear, tmr_b_clear, irq;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [4:0]  counter_module_match;
   logic [23:0] irq_vector, last_vec;
   logic [2:0]  irq_stack_bytes, last_stack;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, ncalls, n0;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          error_cnt, checked;
   interrupt_priority_vectoring i_interrupt_priority_vectoring (
      .aclk, .aresetn, .ext_irq_a_n, .ext_irq_b_n, .tmr_a_overflow, .tmr_b_overflow, .tmr_c_overflow,
      .tmr_c_external_flag, .serial_rx_done, .serial_tx_done, .counter_array_overflow,
      .counter_module_match, .trap_exec, .core_ack, .core_reti, .irq_call, .irq_vector, .irq_stack_bytes,
      .tmr_a_clear, .tmr_b_clear, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
   );
   core_model i_core_model (
      .aclk, .aresetn, .irq_call, .irq_vector, .irq_stack_bytes, .core_ack, .core_reti,
      .last_vec, .last_stack, .ncalls
   );
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   // Timer peripherals drop their flags when told to
   always @(posedge aclk) begin
      if (tmr_a_clear) tmr_a_overflow <= 1'b0;
      if (tmr_b_clear) tmr_b_overflow <= 1'b0;
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b0;
      chk("bresp", 32'(s_axi_bresp), 32'(er));
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      {s_axi_arvalid, s_axi_rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b0;
      chk("rdata", s_axi_rdata, ed);
      chk("rresp", 32'(s_axi_rresp), 32'(er));
   endtask : rd
   task automatic wcall(input logic [23:0] ev, input logic [2:0] es);
      int t;
      n0 = ncalls;
      t = 0;
      while (ncalls === n0 && t < 200) begin
         @(posedge aclk);
         t++;
      end
      chk("call", 32'(ncalls !== n0), 32'h1);
      chk("vector", 32'(last_vec), 32'(ev));
      chk("stack", 32'(last_stack), 32'(es));
   endtask : wcall
   task end_of_test;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (20000) @(posedge aclk);
      error_cnt++;
      end_of_test;
   end
   initial begin
      {aresetn, tmr_a_overflow, tmr_b_overflow, tmr_c_overflow, tmr_c_external_flag, serial_rx_done} = '0;
      {serial_tx_done, counter_array_overflow, counter_module_match, trap_exec, s_axi_awvalid} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      {error_cnt, checked, s_axi_wdata} = '0;
      {ext_irq_a_n, ext_irq_b_n, s_axi_wstrb} = '1;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      rd(irq_pkg::ADDR_ENABLE, 32'h0, irq_pkg::RESP_OKAY);
      rd(8'hFC, 32'h0, irq_pkg::RESP_SLVERR);
      wr(8'hFC, 32'hFF, irq_pkg::RESP_SLVERR);
      // Source enabled but global enable off
      wr(irq_pkg::ADDR_ENABLE, 32'h7F, irq_pkg::RESP_OKAY);
      tmr_a_overflow <= 1'b1;
      repeat (40) @(posedge aclk);
      chk("ncalls", 32'(ncalls), 32'h0);
      wr(irq_pkg::ADDR_ENABLE, 32'hFF, irq_pkg::RESP_OKAY);
      wcall(VB + VS, irq_pkg::STACK_FULL);
      repeat (3) @(posedge aclk);
      chk("tmr_a", 32'(tmr_a_overflow), 32'h0);
      repeat (12) @(posedge aclk);
      tmr_b_overflow <= 1'b1;
      serial_rx_done <= 1'b1;
      wcall(24'(VB + 3 * VS), irq_pkg::STACK_FULL);
      wcall(24'(VB + 4 * VS), irq_pkg::STACK_FULL);
      serial_rx_done <= 1'b0;
      repeat (12) @(posedge aclk);
      // Lowest fixed order source raised to top level
      wr(irq_pkg::ADDR_MODE, 32'h1, irq_pkg::RESP_OKAY);
      wr(irq_pkg::ADDR_PRIO, 32'h3000, irq_pkg::RESP_OKAY);
      ext_irq_a_n <= 1'b0;
      counter_array_overflow <= 1'b1;
      wcall(24'(VB + 6 * VS), irq_pkg::STACK_LEGACY);
      counter_array_overflow <= 1'b0;
      wcall(VB, irq_pkg::STACK_LEGACY);
      ext_irq_a_n <= 1'b1;
      repeat (12) @(posedge aclk);
      // Pin A edge sensed at top level, counter array also top
      wr(irq_pkg::ADDR_MODE, 32'h3, irq_pkg::RESP_OKAY);
      wr(irq_pkg::ADDR_PRIO, 32'h3003, irq_pkg::RESP_OKAY);
      tmr_c_overflow <= 1'b1;
      trap_exec <= 1'b1;
      @(posedge aclk);
      trap_exec <= 1'b0;
      wcall(irq_pkg::VEC_TRAP, irq_pkg::STACK_LEGACY);
      wcall(24'(VB + 5 * VS), irq_pkg::STACK_LEGACY);
      tmr_c_overflow <= 1'b0;
      // Short edge on pin A preempts the level-0 handler
      ext_irq_a_n <= 1'b0;
      repeat (2) @(posedge aclk);
      ext_irq_a_n <= 1'b1;
      wcall(VB, irq_pkg::STACK_LEGACY);
      // Only the preempting handler returns, level 0 stays recorded
      repeat (40) @(posedge aclk);
      rd(irq_pkg::ADDR_PEND, 32'h80, irq_pkg::RESP_OKAY);
      // Interrupt output: masked, unmasked, cleared
      chk("irq", 32'(irq), 32'h0);
      wr(irq_pkg::ADDR_MASK, 32'h3, irq_pkg::RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("irq", 32'(irq), 32'h1);
      rd(irq_pkg::ADDR_STATUS, 32'h3, irq_pkg::RESP_OKAY);
      wr(irq_pkg::ADDR_STATUS, 32'h3, irq_pkg::RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk("irq", 32'(irq), 32'h0);
      rd(irq_pkg::ADDR_STATUS, 32'h0, irq_pkg::RESP_OKAY);
      end_of_test;
   end
endmodule : tb
`default_nettype wire
